/* design/vic_pkg.sv */
// Shared constants and carriers for the vectored interrupt controller.
// Assumes a peripheral bus master with the usual setup and access phases.
package vic_pkg;

   // Register offsets (byte addresses inside the block)
   localparam logic [8:0] VIC_IRQ_ACTIVE = 9'h000;
   localparam logic [8:0] VIC_IRQ_RAW = 9'h004;
   localparam logic [8:0] VIC_IRQ_EN_SET = 9'h008;
   localparam logic [8:0] VIC_IRQ_EN_CLR = 9'h00c;
   localparam logic [8:0] VIC_SOFT_CFG = 9'h010;
   localparam logic [8:0] VIC_VEC_BASE = 9'h014;
   localparam logic [8:0] VIC_IRQ_VEC = 9'h01c;
   localparam logic [8:0] VIC_PRIO_0 = 9'h020;
   localparam logic [8:0] VIC_PRIO_1 = 9'h024;
   localparam logic [8:0] VIC_PRIO_2 = 9'h028;
   localparam logic [8:0] VIC_NEST_CTRL = 9'h030;
   localparam logic [8:0] VIC_EXT_TRIG = 9'h034;
   localparam logic [8:0] VIC_EXT_CLR = 9'h038;
   localparam logic [8:0] VIC_IRQ_STAT = 9'h03c;
   localparam logic [8:0] VIC_FIQ_ACTIVE = 9'h100;
   localparam logic [8:0] VIC_FIQ_RAW = 9'h104;
   localparam logic [8:0] VIC_FIQ_EN_SET = 9'h108;
   localparam logic [8:0] VIC_FIQ_EN_CLR = 9'h10c;
   localparam logic [8:0] VIC_FIQ_VEC = 9'h11c;
   localparam logic [8:0] VIC_FIQ_STAT = 9'h13c;

   // Reset value of every register
   localparam logic [31:0] VIC_RST_VAL = 32'h0000_0000;

   // Field layout
   localparam int VIC_PRIO_FW = 4;
   localparam int VIC_PRIO_PER_REG = 8;
   localparam int VIC_PRIO_SRCS = 20;
   localparam int VIC_BASE_LSB = 6;
   localparam int VIC_NEST_IRQ = 0;
   localparam int VIC_NEST_FIQ = 1;
   localparam int VIC_STAT_BUSY = 3;

   // External trigger encoding, two bits per input
   localparam logic [1:0] VIC_TRIG_RISE = 2'h0;
   localparam logic [1:0] VIC_TRIG_FALL = 2'h1;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [8:0] paddr;
      logic [31:0] pwdata;
   } vic_apb_s;

   typedef struct packed {
      logic hit;
      logic [4:0] idx;
      logic [2:0] prio;
   } vic_pick_s;

endpackage

/* design/vic_top.sv */
// Vectored interrupt controller with a normal and a fast request path.
// Assumes a peripheral bus master, synchronous source inputs and a core
// that pulses an acknowledge when it takes each exception.
//
// Notes on behaviour
// - Peripheral bus register access takes two cycles
// - Normal raw register shows every source level; edge-mode external inputs show their latch
// - Normal disable write clears only selected enables
// - Vector base points at 64-byte, 32-entry table
// - Normal vector gives winning handler address
// - Priority levels 0 to 7 choose winner
// - First priority register: nibble per source 0-7
// - Second priority register: sources 8 to 15
// - Third priority register: sources 16 to 19
// - Nesting enables let higher priority preempt
// - External inputs: rising, falling or level
// - Edge clear write rearms latched external edge
// - Normal status records level of taken exception
// - Software can raise requests by register write
// - Fast path has its own raw readout
// - Fast disable write clears only selected enables
// - Fast status records level of taken exception
`timescale 1ns/1ps

module vic_top #(
   parameter int NSRC = 32,
   parameter int EXT_N = 4,
   parameter int EXT_FIRST = 12
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire vic_pkg::vic_apb_s apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NSRC-1:0] irq_src,
   input wire logic [EXT_N-1:0] ext_pin,
   input wire logic irq_ack,
   input wire logic fiq_ack,
   output logic irq_req,
   output logic fiq_req
);
   import vic_pkg::*;

   if (NSRC < VIC_PRIO_SRCS || NSRC > 32 || EXT_FIRST + EXT_N > NSRC || EXT_N > 16) begin : g_chk
      $error("vic_top: unsupported source or external input count");
   end

   // Path 0 is the normal request path, path 1 the fast one
   logic [1:0][NSRC-1:0] en_q, en_d;
   logic [NSRC-1:0] swi_q, swi_d;
   logic [31:0] base_q, base_d;
   logic [2:0][31:0] prio_q, prio_d;
   logic [1:0] nest_q, nest_d;
   logic [31:0] trig_q, trig_d;
   logic [EXT_N-1:0] latch_q, latch_d, prev_q;
   logic [1:0][3:0] stat_q, stat_d;
   logic [1:0][31:0] vec_q, vec_d;
   logic [31:0] prdata_q, prdata_d;

   logic wr, rd_setup, mapped;
   logic [31:0] rdata;
   logic [NSRC-1:0] ext_vec, raw;
   logic [1:0][NSRC-1:0] act;
   vic_pick_s [1:0] pick;
   logic [1:0] ack, req;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   function automatic logic [2:0] prio_of(input logic [2:0][31:0] p, input int i);
      logic [2:0] r;
      r = 3'h0;
      if (i < VIC_PRIO_SRCS) begin
         r = p[i / VIC_PRIO_PER_REG][(i % VIC_PRIO_PER_REG) * VIC_PRIO_FW +: 3];
      end
      return r;
   endfunction

   // Lower level wins; on a tie the lower source number wins
   function automatic vic_pick_s pick_f(input logic [NSRC-1:0] a, input logic [2:0][31:0] p);
      vic_pick_s r;
      r = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (a[i] && (!r.hit || prio_of(p, i) < r.prio)) begin
            r.hit = 1'b1;
            r.idx = 5'(i);
            r.prio = prio_of(p, i);
         end
      end
      return r;
   endfunction

   // Bus decode; no wait states, so every access is setup plus access
   assign wr = apb.psel && apb.penable && apb.pwrite;
   assign rd_setup = apb.psel && !apb.penable && !apb.pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_q;

   always_comb begin
      unique case (apb.paddr)
         VIC_IRQ_ACTIVE, VIC_IRQ_RAW, VIC_IRQ_EN_SET, VIC_IRQ_EN_CLR, VIC_SOFT_CFG,
         VIC_VEC_BASE, VIC_IRQ_VEC, VIC_PRIO_0, VIC_PRIO_1, VIC_PRIO_2, VIC_NEST_CTRL,
         VIC_EXT_TRIG, VIC_EXT_CLR, VIC_IRQ_STAT, VIC_FIQ_ACTIVE, VIC_FIQ_RAW,
         VIC_FIQ_EN_SET, VIC_FIQ_EN_CLR, VIC_FIQ_VEC, VIC_FIQ_STAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Reserved locations answer with an error and change nothing
   assign pslverr = apb.psel && apb.penable && !mapped;

   // External inputs: edge latches or plain levels
   always_comb begin
      ext_vec = '0;
      latch_d = latch_q;
      for (int e = 0; e < EXT_N; e++) begin
         logic edge_ev;
         logic [1:0] mode;
         edge_ev = 1'b0;
         mode = trig_q[2 * e +: 2];
         if (mode == VIC_TRIG_RISE) begin
            edge_ev = ext_pin[e] && !prev_q[e];
         end else if (mode == VIC_TRIG_FALL) begin
            edge_ev = !ext_pin[e] && prev_q[e];
         end
         // A new edge in the clearing cycle is kept
         if (wr && apb.paddr == VIC_EXT_CLR && apb.pwdata[EXT_FIRST + e]) begin
            latch_d[e] = 1'b0;
         end
         if (edge_ev) begin
            latch_d[e] = 1'b1;
         end
         if (mode == VIC_TRIG_RISE || mode == VIC_TRIG_FALL) begin
            ext_vec[EXT_FIRST + e] = latch_q[e];
         end else begin
            ext_vec[EXT_FIRST + e] = ext_pin[e];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         latch_q <= '0;
         prev_q <= '0;
      end else begin
         latch_q <= latch_d;
         prev_q <= ext_pin;
      end
   end

   // Both paths see the same raw state, enabled or not
   assign raw = irq_src | swi_q | ext_vec;
   assign ack = {fiq_ack, irq_ack};

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         act[p] = raw & en_q[p];
         pick[p] = pick_f(act[p], prio_q);
         // Busy path only requests again for a strictly better level
         req[p] = pick[p].hit && (!stat_q[p][VIC_STAT_BUSY]
            || (nest_q[p] && pick[p].prio < stat_q[p][2:0]));
      end
   end

   assign irq_req = req[0];
   assign fiq_req = req[1];

   // Register file next values
   always_comb begin
      en_d = en_q;
      swi_d = swi_q;
      base_d = base_q;
      prio_d = prio_q;
      nest_d = nest_q;
      trig_d = trig_q;
      stat_d = stat_q;
      if (wr) begin
         unique case (apb.paddr)
            VIC_IRQ_EN_SET: en_d[0] = en_q[0] | apb.pwdata[NSRC-1:0];
            VIC_IRQ_EN_CLR: en_d[0] = en_q[0] & ~apb.pwdata[NSRC-1:0];
            VIC_FIQ_EN_SET: en_d[1] = en_q[1] | apb.pwdata[NSRC-1:0];
            VIC_FIQ_EN_CLR: en_d[1] = en_q[1] & ~apb.pwdata[NSRC-1:0];
            VIC_SOFT_CFG: swi_d = apb.pwdata[NSRC-1:0];
            VIC_VEC_BASE: base_d = apb.pwdata;
            VIC_PRIO_0: prio_d[0] = apb.pwdata;
            VIC_PRIO_1: prio_d[1] = apb.pwdata;
            VIC_PRIO_2: prio_d[2] = apb.pwdata;
            VIC_NEST_CTRL: nest_d = apb.pwdata[VIC_NEST_FIQ:VIC_NEST_IRQ];
            VIC_EXT_TRIG: trig_d = apb.pwdata;
            // Handler exit: software writes back the level it returns to
            VIC_IRQ_STAT: stat_d[0] = {1'b0, apb.pwdata[2:0]};
            VIC_FIQ_STAT: stat_d[1] = {1'b0, apb.pwdata[2:0]};
            default: ;
         endcase
      end
      // Taking an exception wins over a status write in the same cycle.
      // Nesting overwrites the level; software saves the old one.
      for (int p = 0; p < 2; p++) begin
         if (ack[p] && pick[p].hit) begin
            stat_d[p] = {1'b1, pick[p].prio};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q <= '0;
         swi_q <= '0;
         base_q <= VIC_RST_VAL;
         prio_q <= '0;
         nest_q <= '0;
         trig_q <= VIC_RST_VAL;
         stat_q <= '0;
      end else begin
         en_q <= en_d;
         swi_q <= swi_d;
         base_q <= base_d;
         prio_q <= prio_d;
         nest_q <= nest_d;
         trig_q <= trig_d;
         stat_q <= stat_d;
      end
   end

   // Vectors: two bytes per entry inside the 64-byte aligned table
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         if (pick[p].hit) begin
            vec_d[p] = {base_q[31:VIC_BASE_LSB], pick[p].idx, 1'b0};
         end else begin
            vec_d[p] = VIC_RST_VAL;
         end
      end
   end

   // Read data is caught in the setup phase and shown in the access phase
   always_comb begin
      unique case (apb.paddr)
         VIC_IRQ_ACTIVE: rdata = 32'(act[0]);
         VIC_IRQ_RAW: rdata = 32'(raw);
         VIC_IRQ_EN_SET: rdata = 32'(en_q[0]);
         VIC_VEC_BASE: rdata = base_q;
         VIC_IRQ_VEC: rdata = vec_q[0];
         VIC_PRIO_0: rdata = prio_q[0];
         VIC_PRIO_1: rdata = prio_q[1];
         VIC_PRIO_2: rdata = prio_q[2];
         VIC_NEST_CTRL: rdata = 32'(nest_q);
         VIC_EXT_TRIG: rdata = trig_q;
         VIC_IRQ_STAT: rdata = 32'(stat_q[0]);
         VIC_FIQ_ACTIVE: rdata = 32'(act[1]);
         VIC_FIQ_RAW: rdata = 32'(raw);
         VIC_FIQ_EN_SET: rdata = 32'(en_q[1]);
         VIC_FIQ_VEC: rdata = vec_q[1];
         VIC_FIQ_STAT: rdata = 32'(stat_q[1]);
         default: rdata = VIC_RST_VAL;
      endcase
      prdata_d = rd_setup ? rdata : prdata_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         vec_q <= '0;
         prdata_q <= VIC_RST_VAL;
      end else begin
         vec_q <= vec_d;
         prdata_q <= prdata_d;
      end
   end

   // Helper: no active normal source beats the chosen one
   logic prio_ok;
   always_comb begin
      prio_ok = 1'b1;
      for (int i = 0; i < NSRC; i++) begin
         if (act[0][i] && prio_of(prio_q, i) < pick[0].prio) begin
            prio_ok = 1'b0;
         end
      end
   end

   bus_ready_a: assert property (apb.psel && apb.penable |-> pready)
      else $error("access phase without ready");
   raw_read_a: assert property (rd_setup && apb.paddr == VIC_IRQ_RAW
      |=> prdata == 32'($past(raw)))
      else $error("raw readout wrong");
   req_cause_a: assert property (irq_req |-> (|(raw & en_q[0])))
      else $error("request without active source");
   irq_disable_a: assert property (wr && apb.paddr == VIC_IRQ_EN_CLR
      |=> (en_q[0] & $past(apb.pwdata[NSRC-1:0])) == '0
      && (en_q[0] | $past(apb.pwdata[NSRC-1:0])) == ($past(en_q[0]) | $past(apb.pwdata[NSRC-1:0])))
      else $error("normal disable wrong");
   fiq_disable_a: assert property (wr && apb.paddr == VIC_FIQ_EN_CLR
      |=> (en_q[1] & $past(apb.pwdata[NSRC-1:0])) == '0)
      else $error("fast disable wrong");
   vec_base_a: assert property (pick[0].hit ##1 !$changed(base_q)
      |-> vec_q[0][31:VIC_BASE_LSB] == base_q[31:VIC_BASE_LSB]
      && vec_q[0][5:1] == $past(pick[0].idx))
      else $error("vector not from base and winner");
   prio_win_a: assert property (pick[0].hit |-> prio_ok)
      else $error("lower priority source chosen");
   nest_block_a: assert property (stat_q[0][VIC_STAT_BUSY] && !nest_q[VIC_NEST_IRQ]
      |-> !irq_req)
      else $error("request while busy without nesting");
   edge_clear_a: assert property (wr && apb.paddr == VIC_EXT_CLR && apb.pwdata[EXT_FIRST]
      && trig_q[1:0] == VIC_TRIG_RISE && !(ext_pin[0] && !prev_q[0]) |=> !latch_q[0])
      else $error("edge latch not cleared");
   irq_status_a: assert property (irq_ack && pick[0].hit
      |=> stat_q[0] == {1'b1, $past(pick[0].prio)}
      ##1 ($stable(stat_q[0]) || $past(ack[0]) || $past(wr)))
      else $error("normal status not recorded");
   fiq_status_a: assert property (fiq_ack && pick[1].hit
      |=> stat_q[1] == {1'b1, $past(pick[1].prio)})
      else $error("fast status not recorded");

   // Bus and register file checks
   prdata_hold_a: assert property (!rd_setup |=> $stable(prdata))
      else $error("read data moved outside a read setup");
   write_land_a: assert property (wr && apb.paddr == VIC_VEC_BASE
      |=> base_q == $past(apb.pwdata))
      else $error("write did not land after access phase");
   fast_raw_a: assert property (rd_setup && apb.paddr == VIC_FIQ_RAW
      |=> prdata == 32'($past(raw)))
      else $error("fast raw readout wrong");
   soft_raise_a: assert property (wr && apb.paddr == VIC_SOFT_CFG
      |=> (raw & $past(apb.pwdata[NSRC-1:0])) == $past(apb.pwdata[NSRC-1:0]))
      else $error("software request not raised");
   en_set_a: assert property (wr && apb.paddr == VIC_IRQ_EN_SET
      |=> (en_q[0] & $past(apb.pwdata[NSRC-1:0])) == $past(apb.pwdata[NSRC-1:0]))
      else $error("normal enable not set");
   prio_field_a: assert property (wr && apb.paddr == VIC_PRIO_0
      |=> prio_of(prio_q, 1) == $past(apb.pwdata[6:4]))
      else $error("source 1 level field wrong");
   prio_mid_a: assert property (wr && apb.paddr == VIC_PRIO_1
      |=> prio_of(prio_q, 9) == $past(apb.pwdata[6:4]))
      else $error("source 9 level field wrong");
   prio_top_a: assert property (wr && apb.paddr == VIC_PRIO_2
      |=> prio_of(prio_q, 19) == $past(apb.pwdata[14:12]))
      else $error("source 19 level field wrong");
   reset_zero_a: assert property ($past(rst)
      |-> en_q == '0 && stat_q == '0 && !irq_req && !fiq_req)
      else $error("state not zero after reset");
   vec_zero_a: assert property (!pick[0].hit |=> vec_q[0] == VIC_RST_VAL)
      else $error("normal vector not zero when idle");
   fiq_vec_a: assert property (pick[1].hit
      |=> vec_q[1][5:1] == $past(pick[1].idx))
      else $error("fast vector not from winner");
   fiq_nest_block_a: assert property (stat_q[1][VIC_STAT_BUSY] && !nest_q[VIC_NEST_FIQ]
      |-> !fiq_req)
      else $error("fast request while busy without nesting");
   busy_clear_a: assert property (wr && apb.paddr == VIC_IRQ_STAT && !(ack[0] && pick[0].hit)
      |=> stat_q[0] == {1'b0, $past(apb.pwdata[2:0])})
      else $error("normal status write wrong");
   fiq_busy_clear_a: assert property (wr && apb.paddr == VIC_FIQ_STAT && !(ack[1] && pick[1].hit)
      |=> stat_q[1] == {1'b0, $past(apb.pwdata[2:0])})
      else $error("fast status write wrong");

   // External input checks on the first input
   level_pass_a: assert property (trig_q[1] |-> ext_vec[EXT_FIRST] == ext_pin[0])
      else $error("level input not passed through");
   rise_latch_a: assert property (trig_q[1:0] == VIC_TRIG_RISE && ext_pin[0] && !prev_q[0]
      |=> latch_q[0])
      else $error("rising edge not latched");
   fall_latch_a: assert property (trig_q[1:0] == VIC_TRIG_FALL && !ext_pin[0] && prev_q[0]
      |=> latch_q[0])
      else $error("falling edge not latched");

   nest_preempt_c: cover property (stat_q[0][VIC_STAT_BUSY] && irq_req);
   edge_capture_c: cover property (latch_q[0] ##[1:20] !latch_q[0]);
   fiq_taken_c: cover property (fiq_req ##1 fiq_ack);
   irq_taken_c: cover property (irq_req ##1 irq_ack);
   level_pin_c: cover property (trig_q[1] && ext_pin[0]);

endmodule

/* tb/tb_vic_top.sv */
// Self-checking bench for the interrupt controller.
// Assumes a zero-wait peripheral bus and the core model on the ack lines.
`timescale 1ns/1ps

module tb_vic_top;
   import vic_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   vic_apb_s apb = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] irq_src = 32'h0000_0000;
   logic [3:0] ext_pin = 4'h0;
   logic irq_ack;
   logic fiq_ack;
   logic irq_req;
   logic fiq_req;
   logic go_irq = 1'b0;
   logic go_fiq = 1'b0;
   logic [3:0] lat = 4'h0;
   int err_count = 0;
   int num_checks = 0;
   localparam logic [31:0] BASE = 32'h1234_5640;

   vic_top dut (.clk_sys(clk_sys), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_src(irq_src), .ext_pin(ext_pin), .irq_ack(irq_ack),
      .fiq_ack(fiq_ack), .irq_req(irq_req), .fiq_req(fiq_req));
   vic_core_model core (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req), .fiq_req(fiq_req),
      .go_irq(go_irq), .go_fiq(go_fiq), .lat(lat), .irq_ack(irq_ack), .fiq_ack(fiq_ack));

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: 1'b1, paddr: a, pwdata: d};
      @(posedge clk_sys);
      apb.penable <= 1'b1;
      @(posedge clk_sys);
      chk("pready", 32'h0000_0001, {31'h0, pready});
      apb <= '0;
   endtask

   task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic e);
      @(posedge clk_sys);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: 1'b0, paddr: a, pwdata: 32'h0000_0000};
      @(posedge clk_sys);
      apb.penable <= 1'b1;
      @(posedge clk_sys);
      d = prdata;
      e = pslverr;
      apb <= '0;
   endtask

   task automatic rc(input string n, input logic [8:0] a, input logic [31:0] x);
      logic [31:0] d;
      logic e;
      rd(a, d, e);
      chk(n, x, d);
   endtask

   task automatic req(input logic [31:0] xi, input logic [31:0] xf);
      @(posedge clk_sys);
      #1;
      chk("irq_req", xi, {31'h0, irq_req});
      chk("fiq_req", xf, {31'h0, fiq_req});
      @(posedge clk_sys);
   endtask

   task automatic take(input logic f, input logic [3:0] l);
      int i;
      @(posedge clk_sys);
      lat <= l;
      if (f) go_fiq <= 1'b1;
      else go_irq <= 1'b1;
      @(posedge clk_sys);
      go_fiq <= 1'b0;
      go_irq <= 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         if ((f ? fiq_ack : irq_ack) === 1'b1) break;
      end
      if (i == 40) begin
         err_count++;
         conclude();
      end
   endtask

   task automatic t_reset();
      logic [8:0] offs [16] = '{VIC_IRQ_ACTIVE, VIC_IRQ_RAW, VIC_IRQ_EN_SET, VIC_VEC_BASE,
         VIC_IRQ_VEC, VIC_PRIO_0, VIC_PRIO_1, VIC_PRIO_2, VIC_NEST_CTRL, VIC_EXT_TRIG,
         VIC_EXT_CLR, VIC_IRQ_STAT, VIC_FIQ_ACTIVE, VIC_FIQ_EN_SET, VIC_FIQ_VEC, VIC_FIQ_STAT};
      foreach (offs[i]) rc("reset value", offs[i], VIC_RST_VAL);
      req(32'h0000_0000, 32'h0000_0000);
   endtask

   task automatic t_enables();
      irq_src <= 32'h0000_0028;
      rc("raw", VIC_IRQ_RAW, 32'h0000_0028);
      rc("fast raw", VIC_FIQ_RAW, 32'h0000_0028);
      wr(VIC_IRQ_EN_SET, 32'h0000_0030);
      rc("active", VIC_IRQ_ACTIVE, 32'h0000_0020);
      req(32'h0000_0001, 32'h0000_0000);
      wr(VIC_IRQ_EN_CLR, 32'h0000_0020);
      rc("enables", VIC_IRQ_EN_SET, 32'h0000_0010);
      req(32'h0000_0000, 32'h0000_0000);
      wr(VIC_FIQ_EN_SET, 32'h0000_0018);
      wr(VIC_FIQ_EN_CLR, 32'h0000_0010);
      rc("fast enables", VIC_FIQ_EN_SET, 32'h0000_0008);
      rc("fast active", VIC_FIQ_ACTIVE, 32'h0000_0008);
      wr(VIC_IRQ_EN_SET, 32'h0000_0028);
   endtask

   task automatic t_vectors();
      wr(VIC_VEC_BASE, BASE);
      wr(VIC_PRIO_0, 32'h0020_5000);
      rc("base", VIC_VEC_BASE, BASE);
      rc("irq vector", VIC_IRQ_VEC, {BASE[31:6], 5'h05, 1'b0});
      rc("fiq vector", VIC_FIQ_VEC, {BASE[31:6], 5'h03, 1'b0});
      wr(VIC_PRIO_1, 32'h7654_3210);
      rc("prio 8-15", VIC_PRIO_1, 32'h7654_3210);
      wr(VIC_PRIO_2, 32'h0000_1234);
      rc("prio 16-19", VIC_PRIO_2, 32'h0000_1234);
   endtask

   task automatic t_nesting();
      take(1'b0, 4'h0);
      req(32'h0000_0000, 32'h0000_0001);
      rc("irq status", VIC_IRQ_STAT, 32'h0000_000a);
      wr(VIC_PRIO_0, 32'h0020_1000);
      req(32'h0000_0000, 32'h0000_0001);
      wr(VIC_NEST_CTRL, 32'h0000_0001);
      req(32'h0000_0001, 32'h0000_0001);
      take(1'b1, 4'h5);
      req(32'h0000_0001, 32'h0000_0000);
      rc("fiq status", VIC_FIQ_STAT, 32'h0000_0009);
      wr(VIC_IRQ_STAT, 32'h0000_0000);
      rc("irq status", VIC_IRQ_STAT, 32'h0000_0000);
      wr(VIC_NEST_CTRL, 32'h0000_0000);
      wr(VIC_IRQ_EN_CLR, 32'hffff_ffff);
      wr(VIC_FIQ_EN_CLR, 32'hffff_ffff);
      irq_src <= 32'h0000_0000;
   endtask

   task automatic pin(input logic [3:0] v, input logic [31:0] x);
      @(posedge clk_sys);
      ext_pin <= v;
      repeat (2) @(posedge clk_sys);
      rc("ext raw", VIC_IRQ_RAW, x);
   endtask

   task automatic t_external();
      pin(4'h1, 32'h0000_1000);
      pin(4'h0, 32'h0000_1000);
      wr(VIC_EXT_CLR, 32'h0000_1000);
      rc("ext cleared", VIC_IRQ_RAW, 32'h0000_0000);
      wr(VIC_EXT_TRIG, 32'h0000_0001);
      pin(4'h1, 32'h0000_0000);
      pin(4'h0, 32'h0000_1000);
      wr(VIC_EXT_CLR, 32'h0000_1000);
      wr(VIC_EXT_TRIG, 32'h0000_0002);
      pin(4'h1, 32'h0000_1000);
      pin(4'h0, 32'h0000_0000);
   endtask

   task automatic t_soft_and_refused();
      logic [31:0] d;
      logic e;
      wr(VIC_SOFT_CFG, 32'h0000_0002);
      rc("soft raw", VIC_IRQ_RAW, 32'h0000_0002);
      rc("soft fast raw", VIC_FIQ_RAW, 32'h0000_0002);
      rc("soft readback", VIC_SOFT_CFG, 32'h0000_0000);
      wr(VIC_SOFT_CFG, 32'h0000_0000);
      rd(9'h040, d, e);
      chk("unmapped error", 32'h0000_0001, {31'h0, e});
      chk("unmapped data", 32'h0000_0000, d);
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_enables();
      t_vectors();
      t_nesting();
      t_external();
      t_soft_and_refused();
      conclude();
   end
endmodule

/* tb/vic_core_model.sv */
// Core model: takes an exception by pulsing an acknowledge for one cycle.
// Assumes the bench arms it with a one-cycle go pulse and a latency.
`timescale 1ns/1ps

module vic_core_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic fiq_req,
   input wire logic go_irq,
   input wire logic go_fiq,
   input wire logic [3:0] lat,
   output logic irq_ack,
   output logic fiq_ack
);
   logic [4:0] ci_q;
   logic [4:0] cf_q;

   // Acknowledge only while the request is still up, as a real core would
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ci_q <= 5'h00;
         cf_q <= 5'h00;
         irq_ack <= 1'b0;
         fiq_ack <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         fiq_ack <= 1'b0;
         if (go_irq) begin
            ci_q <= {1'b0, lat} + 5'h01;
         end else if (ci_q == 5'h01 && irq_req) begin
            ci_q <= 5'h00;
            irq_ack <= 1'b1;
         end else if (ci_q > 5'h01) begin
            ci_q <= ci_q - 5'h01;
         end
         if (go_fiq) begin
            cf_q <= {1'b0, lat} + 5'h01;
         end else if (cf_q == 5'h01 && fiq_req) begin
            cf_q <= 5'h00;
            fiq_ack <= 1'b1;
         end else if (cf_q > 5'h01) begin
            cf_q <= cf_q - 5'h01;
         end
      end
   end
endmodule
